// ### hdl/epv_prog.v
// Operation
// - Each transfer moves one byte on eight data lines.
// - Address and data stand stable before and during the program strobe; data drive resumes on the same edge that starts the final pulse.
// - Program: chip enable low, output enable high, supply high, strobe low.
// - Bytes may be written in any order, singly or whole array.
// - Prime pulse lasts 1 ms; verify after each prime pulse.
// - On mismatch repeat prime pulses, at most fifteen per byte.
// - After a match apply final pulse of 4 ms times prime count.
// - After the pass, read and compare every byte at nominal supply; the code checks from the loaded address to 13'h1FFF against one data value.
// - Protect: enables, strobe, A4 high, supply and test raised, pulse D7 low.
// - Byte address has 13 lines; high byte even, low byte odd.
`timescale 1ns/100ps
`include "epv_regs.vh"
// Pulse lengths in clock cycles; a bench may shorten them to keep runs brief.
module epv_prog #(
  parameter PRIME_CYC = `EPV_PRIME_CYC,
  parameter FINAL_CYC = `EPV_FINAL_CYC
) (
  input wire sys_clk,
  input wire rst_b,
  input wire [3:0] cmd_addr,
  input wire [31:0] cmd_wdata,
  input wire cmd_wr,
  input wire cmd_rd,
  output reg [31:0] cmd_rdata,
  output reg [12:0] byte_address_lines,
  output reg [7:0] byte_data_lines_out,
  output reg byte_data_lines_oe_n,
  input wire [7:0] byte_data_lines_in,
  output reg chip_enable_n,
  output reg output_enable_n,
  output reg program_strobe_n,
  output reg vpp_raise,
  output reg vcc_raise,
  output reg test_mode_select,
  output reg core_reset_input,
  output reg core_clock_input
);
  localparam S_IDLE = 4'h0;
  localparam S_PSET = 4'h1;
  localparam S_PRIME = 4'h2;
  localparam S_VSET = 4'h3;
  localparam S_VCHK = 4'h4;
  localparam S_FINAL = 4'h5;
  localparam S_RSET = 4'h6;
  localparam S_RCAP = 4'h7;
  localparam S_XSET = 4'h8;
  localparam S_XPULSE = 4'h9;
  localparam S_QSET = 4'hA;
  localparam S_QCAP = 4'hB;
  localparam S_END = 4'hC;

  reg [3:0] state_reg;
  reg [2:0] op_reg;
  reg [12:0] addr_reg;
  reg [7:0] data_reg;
  reg [7:0] rdat_reg;
  reg [3:0] prime_reg;
  reg [3:0] final_reg;
  reg busy_reg;
  reg done_reg;
  reg fail_reg;
  reg prot_reg;
  reg [12:0] bad_addr_reg;
  reg tload;
  reg [31:0] tcount;
  wire tdone;

  // Register address decode shared by read and write paths.
  function is_reg;
    input [3:0] a;
    input [3:0] r;
    begin
      is_reg = (a == r);
    end
  endfunction

  epv_timer u_timer (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .load(tload),
    .count(tcount),
    .done(tdone)
  );

  // Register read port; data valid the cycle after the strobe.
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_rdata <= 32'h0;
    end else if (cmd_rd) begin
      if (is_reg(cmd_addr, `EPV_ADDR_ADDR))
        cmd_rdata <= {19'h0, addr_reg};
      else if (is_reg(cmd_addr, `EPV_ADDR_DATA))
        cmd_rdata <= {24'h0, data_reg};
      else if (is_reg(cmd_addr, `EPV_ADDR_STAT))
        cmd_rdata <= {28'h0, prot_reg, fail_reg, done_reg, busy_reg};
      else if (is_reg(cmd_addr, `EPV_ADDR_RDAT))
        cmd_rdata <= {11'h0, bad_addr_reg, rdat_reg};
      else if (is_reg(cmd_addr, `EPV_ADDR_CNT))
        cmd_rdata <= {28'h0, prime_reg};
      else
        cmd_rdata <= 32'h0;
    end else begin
      cmd_rdata <= 32'h0;
    end
  end

  // Programming sequencer driving the device pins.
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= S_IDLE;
      op_reg <= 3'h0;
      addr_reg <= 13'h0;
      data_reg <= 8'hFF;
      rdat_reg <= 8'hFF;
      prime_reg <= 4'h0;
      final_reg <= 4'h0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      fail_reg <= 1'b0;
      prot_reg <= 1'b0;
      bad_addr_reg <= 13'h0;
      tload <= 1'b0;
      tcount <= 32'h0;
      byte_address_lines <= 13'h0;
      byte_data_lines_out <= 8'hFF;
      byte_data_lines_oe_n <= 1'b1;
      chip_enable_n <= 1'b1;
      output_enable_n <= 1'b1;
      program_strobe_n <= 1'b1;
      vpp_raise <= 1'b0;
      vcc_raise <= 1'b0;
      test_mode_select <= 1'b0;
      core_reset_input <= 1'b0;
      core_clock_input <= 1'b0;
    end else begin
      tload <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          chip_enable_n <= 1'b1;
          output_enable_n <= 1'b1;
          program_strobe_n <= 1'b1;
          byte_data_lines_oe_n <= 1'b1;
          test_mode_select <= 1'b0;
          vpp_raise <= 1'b0;
          vcc_raise <= 1'b0;
          if (cmd_wr && is_reg(cmd_addr, `EPV_ADDR_ADDR))
            addr_reg <= cmd_wdata[12:0];
          if (cmd_wr && is_reg(cmd_addr, `EPV_ADDR_DATA))
            data_reg <= cmd_wdata[7:0];
          if (cmd_wr && is_reg(cmd_addr, `EPV_ADDR_CTRL)) begin
            op_reg <= cmd_wdata[2:0];
            busy_reg <= 1'b1;
            done_reg <= 1'b0;
            fail_reg <= 1'b0;
            prime_reg <= 4'h0;
            byte_address_lines <= addr_reg;
            tload <= 1'b1;
            tcount <= `EPV_SETUP_CYC;
            case (cmd_wdata[2:0])
              `EPV_CMD_PROG: begin
                chip_enable_n <= 1'b0;
                vpp_raise <= 1'b1;
                vcc_raise <= 1'b1;
                byte_data_lines_out <= data_reg;
                byte_data_lines_oe_n <= 1'b0;
                state_reg <= S_PSET;
              end
              `EPV_CMD_READ, `EPV_CMD_VPASS: begin
                chip_enable_n <= 1'b0;
                state_reg <= S_RSET;
              end
              `EPV_CMD_PROT: begin
                vpp_raise <= 1'b1;
                vcc_raise <= 1'b1;
                test_mode_select <= 1'b1;
                byte_address_lines <= addr_reg | 13'h0010;
                byte_data_lines_out <= 8'hFF;
                byte_data_lines_oe_n <= 1'b0;
                state_reg <= S_XSET;
              end
              `EPV_CMD_PVFY: begin
                chip_enable_n <= 1'b0;
                vcc_raise <= 1'b1;
                test_mode_select <= 1'b1;
                byte_address_lines <= addr_reg & 13'h1FBF;
                state_reg <= S_QSET;
              end
              default: begin
                busy_reg <= 1'b0;
                done_reg <= 1'b1;
                state_reg <= S_IDLE;
              end
            endcase
          end
        end
        S_PSET: if (tdone) begin
          program_strobe_n <= 1'b0;
          prime_reg <= prime_reg + 4'h1;
          tload <= 1'b1;
          tcount <= PRIME_CYC;
          state_reg <= S_PRIME;
        end
        S_PRIME: if (tdone) begin
          program_strobe_n <= 1'b1;
          byte_data_lines_oe_n <= 1'b1;
          tload <= 1'b1;
          tcount <= `EPV_SETUP_CYC;
          state_reg <= S_VSET;
        end
        S_VSET: if (tdone) begin
          output_enable_n <= 1'b0;
          tload <= 1'b1;
          tcount <= `EPV_SETUP_CYC;
          state_reg <= S_VCHK;
        end
        S_VCHK: if (tdone) begin
          rdat_reg <= byte_data_lines_in;
          output_enable_n <= 1'b1;
          byte_data_lines_oe_n <= 1'b0;
          tload <= 1'b1;
          if (byte_data_lines_in == data_reg) begin
            final_reg <= prime_reg;
            program_strobe_n <= 1'b0;
            tcount <= FINAL_CYC;
            state_reg <= S_FINAL;
          end else if (prime_reg == `EPV_MAX_PRIME) begin
            fail_reg <= 1'b1;
            bad_addr_reg <= addr_reg;
            byte_data_lines_oe_n <= 1'b1;
            state_reg <= S_END;
          end else begin
            tcount <= `EPV_SETUP_CYC;
            state_reg <= S_PSET;
          end
        end
        S_FINAL: if (tdone) begin
          if (final_reg > 4'h1) begin
            final_reg <= final_reg - 4'h1;
            tload <= 1'b1;
            tcount <= FINAL_CYC;
          end else begin
            program_strobe_n <= 1'b1;
            byte_data_lines_oe_n <= 1'b1;
            state_reg <= S_END;
          end
        end
        S_RSET: if (tdone) begin
          output_enable_n <= 1'b0;
          tload <= 1'b1;
          tcount <= `EPV_SETUP_CYC;
          state_reg <= S_RCAP;
        end
        S_RCAP: if (tdone) begin
          rdat_reg <= byte_data_lines_in;
          output_enable_n <= 1'b1;
          if (op_reg == `EPV_CMD_VPASS && byte_data_lines_in != data_reg) begin
            fail_reg <= 1'b1;
            bad_addr_reg <= byte_address_lines;
            state_reg <= S_END;
          end else if (op_reg == `EPV_CMD_VPASS &&
                       byte_address_lines != `EPV_LAST_ADDR) begin
            byte_address_lines <= byte_address_lines + 13'h1;
            chip_enable_n <= 1'b1;
            tload <= 1'b1;
            tcount <= `EPV_SETUP_CYC;
            state_reg <= S_XSET;
          end else begin
            state_reg <= S_END;
          end
        end
        S_XSET: if (tdone) begin
          tload <= 1'b1;
          if (op_reg == `EPV_CMD_VPASS) begin
            chip_enable_n <= 1'b0;
            tcount <= `EPV_SETUP_CYC;
            state_reg <= S_RSET;
          end else begin
            byte_data_lines_out <= 8'h7F;
            tcount <= PRIME_CYC;
            state_reg <= S_XPULSE;
          end
        end
        S_XPULSE: if (tdone) begin
          byte_data_lines_out <= 8'hFF;
          byte_data_lines_oe_n <= 1'b1;
          state_reg <= S_END;
        end
        S_QSET: if (tdone) begin
          output_enable_n <= 1'b0;
          tload <= 1'b1;
          tcount <= `EPV_SETUP_CYC;
          state_reg <= S_QCAP;
        end
        S_QCAP: if (tdone) begin
          prot_reg <= ~byte_data_lines_in[7];
          rdat_reg <= byte_data_lines_in;
          output_enable_n <= 1'b1;
          state_reg <= S_END;
        end
        S_END: begin
          chip_enable_n <= 1'b1;
          output_enable_n <= 1'b1;
          program_strobe_n <= 1'b1;
          byte_data_lines_oe_n <= 1'b1;
          vpp_raise <= 1'b0;
          vcc_raise <= 1'b0;
          test_mode_select <= 1'b0;
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
          state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule

// ### hdl/epv_regs.vh
`ifndef EPV_REGS_VH
`define EPV_REGS_VH
// Command register offsets of the controller's own port.
`define EPV_ADDR_CTRL 4'h0
`define EPV_ADDR_ADDR 4'h1
`define EPV_ADDR_DATA 4'h2
`define EPV_ADDR_STAT 4'h3
`define EPV_ADDR_RDAT 4'h4
`define EPV_ADDR_CNT 4'h5
// Command codes written to the control register.
`define EPV_CMD_PROG 3'h1
`define EPV_CMD_READ 3'h2
`define EPV_CMD_PROT 3'h3
`define EPV_CMD_PVFY 3'h4
`define EPV_CMD_VPASS 3'h5
// Status register bit positions.
`define EPV_ST_BUSY 0
`define EPV_ST_DONE 1
`define EPV_ST_FAIL 2
`define EPV_ST_PROT 3
// Timing figures and derived counts at 250 MHz.
`define EPV_CLK_NS 4
`define EPV_PRIME_US 1000
`define EPV_FINAL_US 4000
`define EPV_PRIME_CYC ((`EPV_PRIME_US * 1000) / `EPV_CLK_NS)
`define EPV_FINAL_CYC ((`EPV_FINAL_US * 1000) / `EPV_CLK_NS)
`define EPV_SETUP_CYC 8
`define EPV_MAX_PRIME 4'hF
`define EPV_LAST_ADDR 13'h1FFF
`endif

// ### hdl/epv_timer.v
`timescale 1ns/100ps
// Down counter for pulse and setup intervals; done pulses one cycle near expiry.
module epv_timer (
  input wire sys_clk,
  input wire rst_b,
  input wire load,
  input wire [31:0] count,
  output reg done
);
  reg [31:0] cnt_reg;
  reg run_reg;

  // Loads a count, decrements and flags expiry three cycles early.
  // The registered load and the registered flag add those cycles back, so the
  // caller sees exactly count cycles between the strobe edge it launches and ends.
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 32'h0;
      run_reg <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        cnt_reg <= count;
        run_reg <= 1'b1;
      end else if (run_reg) begin
        if (cnt_reg <= 32'h3) begin
          run_reg <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - 32'h1;
        end
      end
    end
  end
endmodule

// ### dv/epv_pin_props.sv
`timescale 1ns/100ps
`include "epv_regs.vh"
// Checks the programmer's pin sequencing against the cell's mode table.
module epv_pin_props #(
  parameter PRIME_CYC = `EPV_PRIME_CYC,
  parameter FINAL_CYC = `EPV_FINAL_CYC
) (
  input wire sys_clk,
  input wire rst_b,
  input wire [12:0] byte_address_lines,
  input wire [7:0] byte_data_lines_out,
  input wire byte_data_lines_oe_n,
  input wire chip_enable_n,
  input wire output_enable_n,
  input wire program_strobe_n,
  input wire vpp_raise,
  input wire test_mode_select,
  input wire vcc_raise,
  input wire core_reset_input,
  input wire core_clock_input
);
  localparam int VWIN = 40;
  reg [31:0] lo_cnt;
  reg [4:0] prime_cnt;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Strobe pulse length, and prime pulses since the cell was selected.
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lo_cnt <= 32'h0;
      prime_cnt <= 5'h0;
    end else begin
      lo_cnt <= program_strobe_n ? 32'h0 : lo_cnt + 32'h1;
      if (chip_enable_n)
        prime_cnt <= 5'h0;
      else if (program_strobe_n && lo_cnt == PRIME_CYC)
        prime_cnt <= prime_cnt + 5'h1;
    end
  end
  sequence prime_end_s;
    $rose(program_strobe_n) && lo_cnt == PRIME_CYC;
  endsequence
  sequence verify_read_s;
    program_strobe_n throughout (##[1:VWIN] !output_enable_n);
  endsequence
  strobe_hold_a: assert property (
    !program_strobe_n |-> $stable(byte_address_lines) && $stable(byte_data_lines_out))
    else $error("address or data moved under strobe");
  prog_level_a: assert property (
    !program_strobe_n |-> !chip_enable_n && output_enable_n && vpp_raise && vcc_raise
    && !byte_data_lines_oe_n)
    else $error("strobe outside program levels");
  verify_after_a: assert property (prime_end_s |-> verify_read_s)
    else $error("no read back after prime pulse");
  prime_limit_a: assert property (prime_end_s |-> prime_cnt < 5'hF)
    else $error("more than fifteen prime pulses");
  final_len_a: assert property (
    $rose(program_strobe_n) && lo_cnt != PRIME_CYC
    |-> prime_cnt != 5'h0 && lo_cnt == FINAL_CYC * prime_cnt)
    else $error("final pulse length wrong");
  bus_turn_a: assert property (
    !output_enable_n |-> byte_data_lines_oe_n && program_strobe_n)
    else $error("controller drives while cell outputs");
  protect_lvl_a: assert property (
    test_mode_select && !byte_data_lines_oe_n && !byte_data_lines_out[7]
    |-> chip_enable_n && output_enable_n && program_strobe_n && vpp_raise && byte_address_lines[4])
    else $error("protect pulse outside protect levels");
  pvfy_lvl_a: assert property (
    test_mode_select && !output_enable_n
    |-> !chip_enable_n && !byte_address_lines[6] && program_strobe_n)
    else $error("protect verify levels wrong");
  core_held_a: assert property (!core_reset_input && !core_clock_input)
    else $error("core reset or clock pin not held low");
endmodule
bind epv_prog epv_pin_props #(.PRIME_CYC(PRIME_CYC), .FINAL_CYC(FINAL_CYC))
  props (.sys_clk(sys_clk), .rst_b(rst_b),
  .byte_address_lines(byte_address_lines), .byte_data_lines_out(byte_data_lines_out),
  .byte_data_lines_oe_n(byte_data_lines_oe_n), .chip_enable_n(chip_enable_n),
  .output_enable_n(output_enable_n), .program_strobe_n(program_strobe_n),
  .vpp_raise(vpp_raise), .test_mode_select(test_mode_select), .vcc_raise(vcc_raise),
  .core_reset_input(core_reset_input), .core_clock_input(core_clock_input));

// ### dv/epv_dev_model.sv
`timescale 1ns/100ps
// Pin-level model of the EPROM cell driven by the programmer.
module epv_dev_model (
  input wire sys_clk,
  input wire [12:0] addr,
  input wire [7:0] wdat,
  input wire wdat_oe_n,
  output wire [7:0] rdat,
  input wire ce_n,
  input wire oe_n,
  input wire pgm_n,
  input wire vpp,
  input wire tms
);
  reg [7:0] mem [0:8191];
  reg security_bit;
  reg [7:0] flt;
  integer i;
  wire rd_en = !ce_n && !oe_n && pgm_n && !tms && security_bit;
  wire pv_en = !ce_n && !oe_n && pgm_n && tms && !addr[6];
  // Erased state: every cell and the security bit read as one.
  initial begin
    security_bit = 1'b1;
    flt = 8'h5A;
    for (i = 0; i < 8192; i = i + 1)
      mem[i] = 8'hFF;
  end
  // Cells only clear, and only at program or protect levels; all other levels inhibit.
  always @(posedge sys_clk) begin
    if (!ce_n && oe_n && !pgm_n && vpp && !tms && !wdat_oe_n)
      mem[addr] <= mem[addr] & wdat;
    if (ce_n && oe_n && pgm_n && addr[4] && vpp && tms && !wdat_oe_n && !wdat[7])
      security_bit <= 1'b0;
    flt <= ~flt + 8'h3B;
  end
  // Line level: controller drive, cell drive, else a pattern that wanders.
  assign rdat = !wdat_oe_n ? wdat : rd_en ? mem[addr] :
    pv_en ? {security_bit, flt[6:0]} : flt;
endmodule

// ### dv/tb.sv
`timescale 1ns/100ps
`include "epv_regs.vh"
`define CHK(nm, e, s) begin n_tests = n_tests + 1; if ((s) !== (e)) begin \
  n_mismatch = n_mismatch + 1; $display("Error %s expected %0h seen %0h", nm, e, s); end end
module tb;
  reg sys_clk = 1'b0;
  reg rst_b = 1'b0;
  reg [3:0] cmd_addr = 4'h0;
  reg [31:0] cmd_wdata = 32'h0;
  reg cmd_wr = 1'b0;
  reg cmd_rd = 1'b0;
  wire [31:0] cmd_rdata;
  wire [12:0] adr;
  wire [7:0] dout, din;
  wire doe_n, ce_n, oe_n, pgm_n, vpp, tms;
  integer n_mismatch = 0;
  integer n_tests = 0;
  integer seed = 32'h6C24;
  integer i;
  reg [31:0] rv;
  reg [12:0] pa;
  reg [7:0] pd;
  // Shortened pulse lengths; the final pulse keeps its four-to-one ratio.
  localparam TB_PRIME = 40;
  localparam TB_FINAL = 160;
  epv_prog #(.PRIME_CYC(TB_PRIME), .FINAL_CYC(TB_FINAL)) uut (.sys_clk(sys_clk),
    .rst_b(rst_b), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata),
    .byte_address_lines(adr), .byte_data_lines_out(dout), .byte_data_lines_oe_n(doe_n),
    .byte_data_lines_in(din), .chip_enable_n(ce_n), .output_enable_n(oe_n),
    .program_strobe_n(pgm_n), .vpp_raise(vpp), .vcc_raise(), .test_mode_select(tms),
    .core_reset_input(), .core_clock_input());
  epv_dev_model dev (.sys_clk(sys_clk), .addr(adr), .wdat(dout), .wdat_oe_n(doe_n),
    .rdat(din), .ce_n(ce_n), .oe_n(oe_n), .pgm_n(pgm_n), .vpp(vpp), .tms(tms));
  // Free-running 250 MHz clock.
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  // Prints the verdict and stops.
  task finish_test;
    begin
      if (n_mismatch == 0 && n_tests > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge sys_clk);
      cmd_addr <= a;
      cmd_wdata <= d;
      cmd_wr <= 1'b1;
      @(posedge sys_clk);
      cmd_wr <= 1'b0;
    end
  endtask
  // Read data stand only in the cycle after the strobe.
  task rd(input [3:0] a, output [31:0] d);
    begin
      @(posedge sys_clk);
      cmd_addr <= a;
      cmd_rd <= 1'b1;
      @(posedge sys_clk);
      cmd_rd <= 1'b0;
      #1 d = cmd_rdata;
    end
  endtask
  // Issues a command and polls status until done, with a bound on the wait.
  task run(input [2:0] c);
    integer t;
    begin
      wr(`EPV_ADDR_CTRL, {29'h0, c});
      rv = 32'h1;
      for (t = 0; rv[`EPV_ST_BUSY] || !rv[`EPV_ST_DONE]; t = t + 1) begin
        if (t > 5000) begin
          n_mismatch = n_mismatch + 1;
          finish_test;
        end
        rd(`EPV_ADDR_STAT, rv);
      end
    end
  endtask
  // Runs one command at a byte address and fetches the result register.
  task byte_at(input [12:0] a, input [2:0] c);
    begin
      wr(`EPV_ADDR_ADDR, {19'h0, a});
      run(c);
      rd(`EPV_ADDR_RDAT, rv);
    end
  endtask
  // Main sequence.
  initial begin
    pa = 13'h1FF8 | ($random(seed) & 13'h6);
    pd = $random(seed) & 8'hBE;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(4'hF, rv);
    `CHK("unmapped", 32'h0, rv)
    byte_at(pa, `EPV_CMD_READ);
    `CHK("erased", 8'hFF, rv[7:0])
    byte_at(13'h0, `EPV_CMD_PVFY);
    `CHK("security_bit clear", 1'b1, rv[7])
    rd(`EPV_ADDR_STAT, rv);
    `CHK("unprotected", 1'b0, rv[`EPV_ST_PROT])
    wr(`EPV_ADDR_DATA, {24'h0, pd});
    byte_at(pa, `EPV_CMD_PROG);
    rd(`EPV_ADDR_STAT, rv);
    `CHK("prog fail", 1'b0, rv[`EPV_ST_FAIL])
    rd(`EPV_ADDR_CNT, rv);
    `CHK("primes", 32'h1, rv)
    byte_at(pa, `EPV_CMD_READ);
    `CHK("programmed", pd, rv[7:0])
    byte_at(pa + 13'h1, `EPV_CMD_READ);
    `CHK("neighbour", 8'hFF, rv[7:0])
    wr(`EPV_ADDR_DATA, 32'hFF);
    byte_at(13'h1FF8, `EPV_CMD_VPASS);
    `CHK("fail addr", pa, rv[20:8])
    rd(`EPV_ADDR_STAT, rv);
    `CHK("pass fail", 1'b1, rv[`EPV_ST_FAIL])
    byte_at(pa + 13'h1, `EPV_CMD_VPASS);
    rd(`EPV_ADDR_STAT, rv);
    `CHK("pass ok", 1'b0, rv[`EPV_ST_FAIL])
    for (i = 0; i < 3; i = i + 1) begin
      run(i == 0 ? 3'h0 : 3'h5 + i[2:0]);
      `CHK("code done", 1'b1, rv[`EPV_ST_DONE])
    end
    byte_at(13'h0, `EPV_CMD_PROT);
    byte_at(13'h0, `EPV_CMD_PVFY);
    `CHK("security_bit set", 1'b0, rv[7])
    rd(`EPV_ADDR_STAT, rv);
    `CHK("protected", 1'b1, rv[`EPV_ST_PROT])
    finish_test;
  end
  // Cuts a hang short; the scenarios need under a thousand cycles, so allow forty thousand.
  initial begin
    #160000;
    n_mismatch = n_mismatch + 1;
    finish_test;
  end
endmodule
